// >>> logic/dma_chan_regs_pkg.sv
// Constants for the per-channel DMA enable, status, fault and mask register set.
// Assumes an APB slave port with 32-bit data and a 12-bit byte address.
//
// Summary of operation
// - Descriptors at fixed table offsets; 16, 17 absent
// - Clearing enable pauses channel, state kept
// - Enable register reads every channel's enable state
// - Writing one sets enable; zero ignored
// - Enable clear register clears bits written one
// - Bit n maps channel n; upper bits reserved
// - Active from start until pipeline drains
// - Busy flag mirrors pipeline occupancy per channel
// - Any fault flag with its mask bit set drives combined interrupt output
// - Fault flags cleared by writing one
// - Mask set bits gate channel interrupts
// - Mask bits cleared only through mask clear
// - Mask clear register clears bits written one
// - Summary bit shows any fault pending
package dma_chan_regs_pkg;

    localparam int          DATA_WIDTH    = 32;
    localparam int          ADDR_WIDTH    = 12;
    localparam int          CHANNEL_COUNT = 20;
    // Channels 16 and 17 are not built
    localparam logic [31:0] CHANNEL_PRESENT = 32'h000c_ffff;

    // Register byte offsets
    localparam logic [11:0] OFFSET_GLOBAL_STATUS   = 12'h004;
    localparam logic [11:0] OFFSET_ENABLE_SET      = 12'h020;
    localparam logic [11:0] OFFSET_ENABLE_CLEAR    = 12'h028;
    localparam logic [11:0] OFFSET_ACTIVE          = 12'h030;
    localparam logic [11:0] OFFSET_OCCUPIED        = 12'h038;
    localparam logic [11:0] OFFSET_FAULT           = 12'h040;
    localparam logic [11:0] OFFSET_IRQ_MASK_SET    = 12'h048;
    localparam logic [11:0] OFFSET_IRQ_MASK_CLEAR  = 12'h050;
    localparam logic [11:0] OFFSET_KILL            = 12'h078;
    localparam logic [11:0] OFFSET_DONE_STATUS     = 12'h080;
    localparam logic [11:0] OFFSET_DONE_MASK       = 12'h084;
    localparam logic [11:0] OFFSET_DESC_LOOKUP     = 12'h088;

    // Field positions
    localparam int          FAULT_SUMMARY_BIT = 2;
    localparam int          LOOKUP_VALID_BIT  = 31;
    localparam int          CHAN_SEL_WIDTH    = 5;

    // Descriptor table layout
    localparam logic [11:0] DESC_STRIDE      = 12'h010;
    localparam logic [11:0] DESC_OFFSET_CH15 = 12'h0f0;
    localparam logic [11:0] DESC_OFFSET_CH18 = 12'h120;
    localparam logic [11:0] DESC_OFFSET_CH19 = 12'h130;
    localparam logic [4:0]  CHAN_15          = 5'h0f;
    localparam logic [4:0]  CHAN_18          = 5'h12;
    localparam logic [4:0]  CHAN_19          = 5'h13;
    localparam logic [4:0]  CHAN_LINEAR_LAST = 5'h0e;

    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Bus answer phase
    typedef enum logic [0:0] {
        BUS_WAIT   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_phase_type;

    // Offset of a channel descriptor in the table; valid flag in bit 12
    function automatic logic [12:0] descriptor_offset(input logic [4:0] chan);
        logic [12:0] result;
        result = 13'h0000;
        case (chan)
            CHAN_15: result = {1'b1, DESC_OFFSET_CH15};
            CHAN_18: result = {1'b1, DESC_OFFSET_CH18};
            CHAN_19: result = {1'b1, DESC_OFFSET_CH19};
            default: begin
                if (chan <= CHAN_LINEAR_LAST) begin
                    result = {1'b1, 12'(DESC_STRIDE * {7'h00, chan})};
                end
            end
        endcase
        return result;
    endfunction : descriptor_offset

endpackage : dma_chan_regs_pkg

// >>> logic/dma_chan_regs.sv
// Per-channel enable, activity, occupancy, fault and interrupt mask registers.
// Assumes an APB master on CLOCK and a transfer engine on the same clock that
// reports start, completion, occupancy and faults as per-channel signals.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps

module dma_chan_regs
    import dma_chan_regs_pkg::*;
#(
    parameter int          NUM_CHANNELS = CHANNEL_COUNT,
    parameter logic [31:0] IMPLEMENTED  = CHANNEL_PRESENT
) (
    input  wire logic                    CLOCK,
    input  wire logic                    RST_N,
    // APB slave
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [ADDR_WIDTH-1:0]   PADDR,
    input  wire logic [DATA_WIDTH-1:0]   PWDATA,
    output logic      [DATA_WIDTH-1:0]   PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    // Transfer engine side
    input  wire logic [NUM_CHANNELS-1:0] OP_START,
    input  wire logic [NUM_CHANNELS-1:0] LAST_DONE,
    input  wire logic [NUM_CHANNELS-1:0] PIPELINE_OCCUPIED,
    input  wire logic [NUM_CHANNELS-1:0] FAULT_EVENT,
    output logic      [NUM_CHANNELS-1:0] CHANNEL_ENABLE,
    output logic      [NUM_CHANNELS-1:0] CHANNEL_KILL,
    output logic                         DMA_IRQ
);

    localparam int PAD = DATA_WIDTH - NUM_CHANNELS;

    // Whole register state of the block
    typedef struct packed {
        bus_phase_type             phase;
        logic [DATA_WIDTH-1:0]     rdata;
        logic                      slverr;
        logic [NUM_CHANNELS-1:0]   enable;
        logic [NUM_CHANNELS-1:0]   active;
        logic [NUM_CHANNELS-1:0]   draining;
        logic [NUM_CHANNELS-1:0]   occupied;
        logic [NUM_CHANNELS-1:0]   fault;
        logic [NUM_CHANNELS-1:0]   irq_mask;
        logic [NUM_CHANNELS-1:0]   done_status;
        logic [NUM_CHANNELS-1:0]   done_mask;
        logic [NUM_CHANNELS-1:0]   kill;
        logic [CHAN_SEL_WIDTH-1:0] desc_sel;
        logic                      irq;
    } state_type;

    state_type state;
    state_type next_state;

    logic [NUM_CHANNELS-1:0] implemented;
    logic [NUM_CHANNELS-1:0] wr_bits;
    logic [DATA_WIDTH-1:0]   read_word;
    logic                    addr_hit;
    logic                    access_wait;
    logic                    access_done;
    logic [12:0]             lookup;

    // Lanes of built channels; reserved lanes stay zero
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_lane
            assign implemented[ch] = IMPLEMENTED[ch];
        end
    endgenerate

    // Bus phase decode
    assign access_wait = PSEL && PENABLE && (state.phase == BUS_WAIT);
    assign access_done = PSEL && PENABLE && (state.phase == BUS_ANSWER);
    assign wr_bits     = PWDATA[NUM_CHANNELS-1:0] & implemented;
    assign lookup      = descriptor_offset(state.desc_sel);

    // Read multiplexer; unmapped offsets flag an error
    always_comb begin
        read_word = RESET_WORD;
        addr_hit  = 1'b1;
        case (PADDR)
            OFFSET_GLOBAL_STATUS: begin
                read_word[FAULT_SUMMARY_BIT] = |state.fault;
            end
            OFFSET_ENABLE_SET:     read_word = {{PAD{1'b0}}, state.enable};
            OFFSET_ENABLE_CLEAR:   read_word = RESET_WORD;
            OFFSET_ACTIVE:         read_word = {{PAD{1'b0}}, state.active};
            OFFSET_OCCUPIED:       read_word = {{PAD{1'b0}}, state.occupied};
            OFFSET_FAULT:          read_word = {{PAD{1'b0}}, state.fault};
            OFFSET_IRQ_MASK_SET:   read_word = {{PAD{1'b0}}, state.irq_mask};
            OFFSET_IRQ_MASK_CLEAR: read_word = RESET_WORD;
            OFFSET_KILL:           read_word = RESET_WORD;
            OFFSET_DONE_STATUS:    read_word = {{PAD{1'b0}}, state.done_status};
            OFFSET_DONE_MASK:      read_word = {{PAD{1'b0}}, state.done_mask};
            OFFSET_DESC_LOOKUP: begin
                read_word[11:0]             = lookup[11:0];
                read_word[LOOKUP_VALID_BIT] = lookup[12];
            end
            default:               addr_hit = 1'b0;
        endcase
    end

    // Next-state logic
    always_comb begin
        next_state      = state;
        next_state.kill = '0;

        // Two-phase APB answer: data and ready prepared, then committed
        if (access_wait) begin
            next_state.phase  = BUS_ANSWER;
            next_state.rdata  = PWRITE ? RESET_WORD : read_word;
            next_state.slverr = ~addr_hit;
        end else if (state.phase == BUS_ANSWER) begin
            next_state.phase  = BUS_WAIT;
            next_state.rdata  = RESET_WORD;
            next_state.slverr = 1'b0;
        end

        // Occupancy mirrors the engine pipeline
        next_state.occupied = PIPELINE_OCCUPIED & implemented;

        // Completion waits for the pipeline to empty after the last descriptor
        next_state.draining = (state.draining | (LAST_DONE & implemented))
                              & ~(state.draining & ~PIPELINE_OCCUPIED);
        next_state.active   = (state.active
                              & ~(state.draining & ~PIPELINE_OCCUPIED))
                              | (OP_START & implemented);
        // Completion event, sticky until read
        next_state.done_status = state.done_status
                                 | (state.active & ~next_state.active);

        // Hardware fault events
        next_state.fault = state.fault | (FAULT_EVENT & implemented);

        // Register writes and read side effects at the committing edge
        if (access_done && addr_hit) begin
            if (PWRITE) begin
                case (PADDR)
                    OFFSET_ENABLE_SET: begin
                        next_state.enable = state.enable | wr_bits;
                    end
                    OFFSET_ENABLE_CLEAR: begin
                        next_state.enable = state.enable & ~wr_bits;
                    end
                    OFFSET_FAULT: begin
                        // New fault in the same cycle wins over the clear
                        next_state.fault = (state.fault & ~wr_bits)
                                           | (FAULT_EVENT & implemented);
                    end
                    OFFSET_IRQ_MASK_SET: begin
                        next_state.irq_mask = state.irq_mask | wr_bits;
                    end
                    OFFSET_IRQ_MASK_CLEAR: begin
                        next_state.irq_mask = state.irq_mask & ~wr_bits;
                    end
                    OFFSET_KILL: begin
                        next_state.kill     = wr_bits;
                        next_state.active   = next_state.active & ~wr_bits;
                        next_state.draining = next_state.draining & ~wr_bits;
                    end
                    OFFSET_DONE_MASK: begin
                        next_state.done_mask = wr_bits;
                    end
                    OFFSET_DESC_LOOKUP: begin
                        next_state.desc_sel = PWDATA[CHAN_SEL_WIDTH-1:0];
                    end
                    default: begin
                        next_state.kill = '0;
                    end
                endcase
            end else if (PADDR == OFFSET_DONE_STATUS) begin
                // Clear only what was returned; a completion in this cycle wins
                next_state.done_status = (state.done_status
                                          & ~state.rdata[NUM_CHANNELS-1:0])
                                         | (state.active & ~next_state.active);
            end
        end

        // Combined interrupt from masked faults and completions
        next_state.irq = |((next_state.fault | next_state.done_status)
                           & next_state.irq_mask)
                         | |(next_state.done_status & next_state.done_mask);
    end

    // State register
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from flip-flops
    assign PRDATA         = state.rdata;
    assign PREADY         = state.phase == BUS_ANSWER;
    assign PSLVERR        = state.slverr;
    assign CHANNEL_ENABLE = state.enable;
    assign CHANNEL_KILL   = state.kill;
    assign DMA_IRQ        = state.irq;

endmodule : dma_chan_regs

// >>> testbench/dma_chan_regs_monitor.sv
// Checker for the APB answer and the channel enable and abort outputs.
// Assumes a bind onto the register block; one clock domain.
`timescale 1ns/100ps

module dma_chan_regs_monitor
    import dma_chan_regs_pkg::*;
#(
    parameter int          NUM_CHANNELS = CHANNEL_COUNT,
    parameter logic [31:0] IMPLEMENTED  = CHANNEL_PRESENT
) (
    input wire logic                    CLOCK,
    input wire logic                    RST_N,
    input wire logic                    PSEL,
    input wire logic                    PENABLE,
    input wire logic                    PWRITE,
    input wire logic [ADDR_WIDTH-1:0]   PADDR,
    input wire logic [DATA_WIDTH-1:0]   PWDATA,
    input wire logic [DATA_WIDTH-1:0]   PRDATA,
    input wire logic                    PREADY,
    input wire logic                    PSLVERR,
    input wire logic [NUM_CHANNELS-1:0] OP_START,
    input wire logic [NUM_CHANNELS-1:0] LAST_DONE,
    input wire logic [NUM_CHANNELS-1:0] PIPELINE_OCCUPIED,
    input wire logic [NUM_CHANNELS-1:0] FAULT_EVENT,
    input wire logic [NUM_CHANNELS-1:0] CHANNEL_ENABLE,
    input wire logic [NUM_CHANNELS-1:0] CHANNEL_KILL,
    input wire logic                    DMA_IRQ
);
    localparam logic [NUM_CHANNELS-1:0] imp_mask = IMPLEMENTED[NUM_CHANNELS-1:0];
    logic                    commit;
    logic [NUM_CHANNELS-1:0] wbits;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Write completing at this edge
    assign commit = PSEL && PENABLE && PREADY && PWRITE;
    assign wbits  = PWDATA[NUM_CHANNELS-1:0];
    // Bus answer timing and idle data
    property p_ready_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("no answer after wait");
    property p_ready_pulse; PREADY |-> $past(PSEL && PENABLE) ##1 !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("stray answer");
    property p_idle_data; !PREADY |-> PRDATA == '0; endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
    property p_err_data; PSLVERR |-> PREADY && PRDATA == '0; endproperty
    a_err_data: assert property (p_err_data) else $error("bad error answer");
    // Enable set, clear and hold
    property p_en_set;
        commit && PADDR == OFFSET_ENABLE_SET |=>
            (CHANNEL_ENABLE & $past(wbits & imp_mask)) == $past(wbits & imp_mask);
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable not set");
    property p_en_clr;
        commit && PADDR == OFFSET_ENABLE_CLEAR |=> (CHANNEL_ENABLE & $past(wbits)) == '0;
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("enable not cleared");
    property p_en_keep;
        !(commit && (PADDR == OFFSET_ENABLE_SET || PADDR == OFFSET_ENABLE_CLEAR))
            |=> $stable(CHANNEL_ENABLE);
    endproperty
    a_en_keep: assert property (p_en_keep) else $error("enable changed alone");
    property p_en_rsvd; (CHANNEL_ENABLE & ~imp_mask) == '0; endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("reserved enable set");
    property p_kill_pulse; CHANNEL_KILL != '0 |=> CHANNEL_KILL == '0; endproperty
    a_kill_pulse: assert property (p_kill_pulse) else $error("abort held too long");
    // Main scenarios reached
    c_en_set: cover property (commit && PADDR == OFFSET_ENABLE_SET);
    c_err: cover property (PSLVERR);
    c_irq: cover property (DMA_IRQ);
    c_kill: cover property (CHANNEL_KILL != '0);
endmodule : dma_chan_regs_monitor

// >>> testbench/tb_dma_chan_regs.sv
// Self-checking bench for the channel register set over APB.
// Assumes the package and the checker are compiled first.
`timescale 1ns/100ps

module tb_dma_chan_regs
    import dma_chan_regs_pkg::*;
;
    logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, w, en, occ;
    logic        pready, pslverr, dma_irq;
    logic [19:0] op_start = '0, last_done = '0, pipeline_occupied = '0, fault_event = '0;
    logic [19:0] channel_enable, channel_kill;
    logic [33:0] notes[$], note;
    logic [11:0] ro[6] = '{12'h020, 12'h030, 12'h038, 12'h040, 12'h048, 12'h004};
    logic [4:0]  dch[4] = '{5'h0f, 5'h12, 5'h13, 5'h10};
    logic [31:0] doff[4] = '{32'h8000_00f0, 32'h8000_0120, 32'h8000_0130, 32'h0};
    int          mismatches = 0, n_checks = 0, cycles = 0, seed = 32'hc80f6816;

    dma_chan_regs i_dut (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OP_START(op_start), .LAST_DONE(last_done),
        .PIPELINE_OCCUPIED(pipeline_occupied), .FAULT_EVENT(fault_event),
        .CHANNEL_ENABLE(channel_enable), .CHANNEL_KILL(channel_kill), .DMA_IRQ(dma_irq));

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // One APB transfer; the expected answer goes to the queue
    task automatic xfer(input logic wt, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] e, input logic er);
        @(posedge clock);
        notes.push_back({~wt, er, e});
        psel <= 1'b1;
        pwrite <= wt;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, e, 1'b0);
    endtask : rd

    task automatic irq(input logic e);
        @(negedge clock);
        check("irq", 32'(dma_irq), 32'(e));
    endtask : irq

    // Clock
    initial begin
        forever #10 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    // Answer watcher against the oldest note
    always @(posedge clock) begin
        if (pready === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            check("pslverr", 32'(pslverr), 32'(note[32]));
            if (note[33]) check("prdata", prdata, note[31:0]);
        end
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        foreach (ro[k]) rd(ro[k], 32'h0);
        $display("test reset done");
        w = $random(seed);
        en = w & CHANNEL_PRESENT;
        wr(12'h020, w);
        wr(12'h020, 32'h0);
        rd(12'h020, en);
        wr(12'h028, w & 32'h0000_ff0f);
        en = en & ~32'h0000_ff0f;
        rd(12'h020, en);
        @(negedge clock);
        check("enable", 32'(channel_enable), en);
        wr(12'h030, 32'hffff_ffff);
        rd(12'h030, 32'h0);
        xfer(1'b0, 12'h0fc, 32'h0, 32'h0, 1'b1);
        $display("test enable done");
        fault_event <= 20'h00020;
        @(posedge clock);
        fault_event <= '0;
        rd(12'h040, 32'h20);
        rd(12'h004, 32'h4);
        irq(1'b0);
        wr(12'h048, 32'h20);
        irq(1'b1);
        wr(12'h048, 32'h0);
        rd(12'h048, 32'h20);
        wr(12'h050, 32'h20);
        irq(1'b0);
        wr(12'h048, 32'h20);
        wr(12'h040, 32'h20);
        irq(1'b0);
        rd(12'h040, 32'h0);
        rd(12'h004, 32'h0);
        foreach (dch[k]) begin
            wr(12'h088, {27'h0, dch[k]});
            rd(12'h088, doff[k]);
        end
        $display("test fault done");
        occ = $random(seed) | 32'h8;
        op_start <= 20'h8;
        pipeline_occupied <= occ[19:0];
        @(posedge clock);
        op_start <= '0;
        last_done <= 20'h8;
        @(posedge clock);
        last_done <= '0;
        wr(12'h028, 32'h8);
        rd(12'h030, 32'h8);
        wr(12'h020, 32'h8);
        rd(12'h020, en | 32'h8);
        rd(12'h030, 32'h8);
        rd(12'h038, occ & CHANNEL_PRESENT);
        pipeline_occupied <= '0;
        repeat (3) @(posedge clock);
        rd(12'h030, 32'h0);
        rd(12'h038, 32'h0);
        wr(12'h078, 32'h8);
        @(negedge clock);
        check("kill", 32'(channel_kill), 32'h8);
        // Completion flag, its own mask and clear on read
        wr(12'h084, 32'h8);
        irq(1'b1);
        rd(12'h080, 32'h8);
        irq(1'b0);
        rd(12'h080, 32'h0);
        rd(12'h084, 32'h8);
        $display("test active done");
        finish_test();
    end
endmodule : tb_dma_chan_regs

bind dma_chan_regs dma_chan_regs_monitor #(.NUM_CHANNELS(NUM_CHANNELS),
    .IMPLEMENTED(IMPLEMENTED)) i_mon (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .OP_START(OP_START), .LAST_DONE(LAST_DONE),
    .PIPELINE_OCCUPIED(PIPELINE_OCCUPIED), .FAULT_EVENT(FAULT_EVENT),
    .CHANNEL_ENABLE(CHANNEL_ENABLE), .CHANNEL_KILL(CHANNEL_KILL), .DMA_IRQ(DMA_IRQ));
